//--- hw/tth_replica.sv
// Functional notes
// - Thermal image recomputed every 5 ms step; step is the exponent increment.
// - Heating current is the largest of the three phase TRMS values.
// - Phase values are true RMS including harmonics up to 31st.
// - New image = sq + (old - sq) * exp(-step/tau), sq = (I/(In*service_factor*ambient_correction_factor))^2.
// - Divisor uses settable pick-up current for full thermal capacity.
// - Divisor also includes the settable service factor.
// - Nominal load for one time constant from zero gives about 63 %.
// - Under nominal load image approaches 100 % and never exceeds it.
// - With zero current image decays exponentially toward zero.
// - Time constants are settings in 0.1 min units.
// - Ambient factor clamped to kmin below tmin and kmax above tmax.
// - Ambient factor interpolated linearly on two segments through the reference.
// - At the reference temperature the ambient factor is exactly one.
// - Ambient factor may instead come from a ten point curve.
// - Sensor source uses measured temperature each step, else manual temperature.
// - On restart image set to settable cold value, default 60 %.
// - Heating time constant while rising, cooling time constant while falling.
// - Ambient source selectable manual or sensor, manual by default.
`timescale 1ns/1ps
module tth_replica
    import tth_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEF
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register bus
    input wire tth_axi_req_t axiReq,
    output tth_axi_rsp_t axiRsp,
    // Measurements
    input wire tth_meas_t meas,
    // Thermal image
    output logic [31:0] thetaOut,
    output logic [15:0] kAmbOut,
    output logic stepDone
);
    tth_state_t state, next_state;
    logic awRdy, wRdy, bVal, arRdy, rVal;
    logic [1:0] bRsp, rRsp;
    logic [31:0] rDat, wDat, stepCnt;
    // Squared ratio and image fraction in Q32, so steps below one image LSB still add up
    logic [47:0] ratioSq;
    logic [15:0] thetaFrac;
    logic [7:0] awAddr;
    logic [3:0] wStb;
    logic [15:0] cfg [CFG_N];
    logic [2:0] ctrl;
    logic enPrev, tauDirty, next_tauDirty, divGo, divDone;
    logic [15:0] iL1, iL2, iL3, rtdT, imax, curveRd;
    logic signed [15:0] tAmb;
    logic [24:0] aHeat, aCool;
    logic [DIV_W-1:0] divNum, divDen, divQ, ambQ;

    function automatic logic [7:0] wordIdx(input logic [7:0] a, input logic [7:0] base);
        wordIdx = (a - base) >> 2;
    endfunction

    function automatic logic inRange(input logic [7:0] a, input logic [7:0] base, input int n);
        inRange = a[1:0] == 2'h0 && a >= base && wordIdx(a, base) < 8'(n);
    endfunction

    function automatic logic [23:0] sat24(input logic [DIV_W-1:0] q);
        sat24 = q > SAT24 ? 24'hFF_FFFF : q[23:0];
    endfunction

    function automatic logic [15:0] max2(input logic [15:0] a, input logic [15:0] b);
        max2 = a > b ? a : b;
    endfunction

    // Bus decode
    wire [7:0] wIdx = wordIdx(awAddr, REG_CFG_BASE);
    wire [7:0] wCurveIdx = wordIdx(awAddr, REG_CURVE_BASE);
    wire wrCfg = inRange(awAddr, REG_CFG_BASE, CFG_N);
    wire wrCurve = inRange(awAddr, REG_CURVE_BASE, CURVE_N);
    wire wrCtrl = awAddr == REG_CTRL;
    wire doWrite = !awRdy && !wRdy && !bVal;
    wire coldCmd = doWrite && wrCtrl && wStb[0] && wDat[CTRL_COLD_BIT];
    wire [7:0] ra = axiReq.araddr;
    wire [7:0] rIdx = wordIdx(ra, REG_CFG_BASE);
    wire rdCfg = inRange(ra, REG_CFG_BASE, CFG_N);
    wire rdOk = ra == REG_CTRL || rdCfg || ra == REG_THETA || ra == REG_AMBIENT_CORRECTION_FACTOR || ra == REG_STATUS
        || inRange(ra, REG_CURVE_BASE, CURVE_N);
    wire [31:0] rdMux = ra == REG_CTRL ? {29'h0, ctrl}
        : rdCfg ? {16'h0, cfg[rIdx[3:0]]}
        : ra == REG_THETA ? thetaOut
        : ra == REG_AMBIENT_CORRECTION_FACTOR ? {16'h0, kAmbOut}
        : ra == REG_STATUS ? {imax, 15'h0, state != S_IDLE} : 32'h0;

    assign axiRsp = '{awready: awRdy, wready: wRdy, bvalid: bVal, bresp: bRsp,
        arready: arRdy, rvalid: rVal, rdata: rDat, rresp: rRsp};

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            awRdy <= 1'b1;
            wRdy <= 1'b1;
            bVal <= 1'b0;
            bRsp <= RESP_OKAY;
            awAddr <= 8'h0;
            wDat <= 32'h0;
            wStb <= 4'h0;
            arRdy <= 1'b1;
            rVal <= 1'b0;
            rDat <= 32'h0;
            rRsp <= RESP_OKAY;
        end
        else
        begin
            if (axiReq.awvalid && awRdy)
            begin
                awRdy <= 1'b0;
                awAddr <= axiReq.awaddr;
            end
            if (axiReq.wvalid && wRdy)
            begin
                wRdy <= 1'b0;
                wDat <= axiReq.wdata;
                wStb <= axiReq.wstrb;
            end
            if (doWrite)
            begin
                bVal <= 1'b1;
                bRsp <= (wrCtrl || wrCfg || wrCurve) ? RESP_OKAY : RESP_DECERR;
            end
            else if (bVal && axiReq.bready)
            begin
                bVal <= 1'b0;
                awRdy <= 1'b1;
                wRdy <= 1'b1;
            end
            if (axiReq.arvalid && arRdy)
            begin
                arRdy <= 1'b0;
                rVal <= 1'b1;
                rDat <= rdMux;
                rRsp <= rdOk ? RESP_OKAY : RESP_DECERR;
            end
            else if (rVal && axiReq.rready)
            begin
                rVal <= 1'b0;
                arRdy <= 1'b1;
            end
        end
    end

    // Settings; a time constant write marks the decay factors stale
    wire tauWrite = doWrite && wrCfg && (wIdx == 8'(CFG_TAUH) || wIdx == 8'(CFG_TAUC));
    wire go = state == S_IDLE && stepCnt == 32'h0 && ctrl[CTRL_EN_BIT];
    assign next_tauDirty = tauWrite || (tauDirty && !(go && next_state == S_XH));
    wire coldReq = coldCmd || (ctrl[CTRL_EN_BIT] && !enPrev);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < CFG_N; i++)
                cfg[i] <= CFG_RST[i];
            ctrl <= 3'h0;
            enPrev <= 1'b0;
            tauDirty <= 1'b1;
        end
        else
        begin
            if (doWrite && wrCfg)
                cfg[wIdx[3:0]] <= {wStb[1] ? wDat[15:8] : cfg[wIdx[3:0]][15:8],
                    wStb[0] ? wDat[7:0] : cfg[wIdx[3:0]][7:0]};
            if (doWrite && wrCtrl && wStb[0])
                ctrl <= wDat[2:0];
            enPrev <= ctrl[CTRL_EN_BIT];
            tauDirty <= next_tauDirty;
        end
    end

    // latest TRMS samples from the measurement chain
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            iL1 <= 16'h0;
            iL2 <= 16'h0;
            iL3 <= 16'h0;
            rtdT <= 16'h0;
        end
        else if (meas.valid)
        begin
            iL1 <= meas.l1;
            iL2 <= meas.l2;
            iL3 <= meas.l3;
            rtdT <= meas.temp;
        end
    end

    // Ambient factor datapath
    wire signed [15:0] tMin = cfg[CFG_TMIN];
    wire signed [15:0] tRef = cfg[CFG_TREF];
    wire signed [15:0] tMax = cfg[CFG_TMAX];
    wire below = tAmb < tRef;
    wire signed [16:0] kStart = below ? {1'b0, cfg[CFG_KMIN]} : {1'b0, AMBIENT_CORRECTION_FACTOR_ONE};
    wire signed [16:0] kEnd = below ? {1'b0, AMBIENT_CORRECTION_FACTOR_ONE} : {1'b0, cfg[CFG_KMAX]};
    wire signed [15:0] tStart = below ? tMin : tRef;
    wire signed [15:0] tEnd = below ? tRef : tMax;
    wire signed [16:0] dk = kEnd - kStart;
    wire signed [16:0] dt = tAmb - tStart;
    wire signed [16:0] span = tEnd - tStart;
    wire signed [16:0] dtMin = tAmb - tMin;
    wire signed [16:0] spanAll = tMax - tMin;
    wire [16:0] dkAbs = dk[16] ? 17'(-dk) : 17'(dk);
    wire [33:0] linNum = 34'(dkAbs) * 34'(dt[16:0]);
    wire [33:0] curveNum = 34'(dtMin[16:0]) * 34'(CURVE_N - 1);
    wire lowClamp = tAmb <= tMin;
    wire highClamp = tAmb >= tMax;
    // two-segment interpolation; at tRef dt is zero
    wire signed [17:0] kLinS = dk[16] ? kStart - 18'(ambQ[16:0]) : kStart + 18'(ambQ[16:0]);
    wire [3:0] cIdx = lowClamp ? 4'h0 : (highClamp || ambQ > 40'(CURVE_N - 1)) ? 4'(CURVE_N - 1) : ambQ[3:0];
    wire [15:0] kNew = ctrl[CTRL_CURVE_BIT] ? curveRd : lowClamp ? cfg[CFG_KMIN]
        : highClamp ? cfg[CFG_KMAX] : kLinS[15:0];

    // divisor In * service_factor * ambient_correction_factor in 0.01 pu
    wire [31:0] pickSf = 32'(cfg[CFG_PICKUP]) * 32'(cfg[CFG_SF]);
    wire [31:0] divPu = pickSf / 32'(SF_SCALE);
    wire [47:0] dAmb = 48'(divPu) * 48'(kAmbOut);
    // tau in 0.1 min; x = step / tau
    wire [15:0] tauSel = state == S_XH ? cfg[CFG_TAUH] : cfg[CFG_TAUC];
    wire [26:0] tauDen = 27'(tauSel == 16'h0 ? 16'h1 : tauSel) * 27'(XDEN_SCALE);
    wire xState = state == S_XH || state == S_XC;

    assign divNum = xState ? DECAY_ONE
        : state == S_AMB ? (ctrl[CTRL_CURVE_BIT] ? 40'(curveNum) : 40'(linNum)) : {8'h0, imax, 16'h0};
    assign divDen = xState ? 40'(tauDen)
        : state == S_AMB ? (ctrl[CTRL_CURVE_BIT] ? 40'(spanAll[15:0]) : 40'(span[15:0]))
        : 40'(dAmb >> AMBIENT_CORRECTION_FACTOR_SHIFT);

    // exp(-x) to second order in Q24
    wire [23:0] xq = sat24(divQ);
    wire [47:0] xx = 48'(xq) * 48'(xq);
    wire [24:0] decayNew = 25'(DECAY_ONE) - {1'b0, xq} + 25'(xx >> (DECAY_FRAC + 1));
    wire [23:0] qSat = sat24(divQ);
    wire [47:0] qSq = 48'(qSat) * 48'(qSat);

    wire heating = ratioSq > {thetaOut, thetaFrac};
    wire [24:0] aSel = heating ? aHeat : aCool;
    // exponential step; result lies between old image and sq
    wire signed [49:0] diff = $signed({2'b00, thetaOut, thetaFrac}) - $signed({2'b00, ratioSq});
    wire signed [75:0] prod = diff * $signed({1'b0, aSel});
    wire signed [75:0] thetaSum = $signed({28'h000_0000, ratioSq}) + (prod >>> DECAY_FRAC);
    wire [32:0] coldMul = 33'(cfg[CFG_COLD]) * 33'(THETA_ONE);
    wire [31:0] coldQ16 = 32'(coldMul / 33'(PCT_SCALE));

    tth_divider u_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(divGo),
        .num(divNum),
        .den(divDen),
        .done(divDone),
        .quot(divQ)
    );

    tth_curve_mem u_curve (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wrEn(doWrite && wrCurve),
        .wrIdx(wCurveIdx[3:0]),
        .wrData(wDat[15:0]),
        .rdIdx(cIdx),
        .rdData(curveRd)
    );

    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE: if (go) next_state = tauDirty ? S_XH : S_AMB;
            S_XH: if (divDone) next_state = S_XC;
            S_XC: if (divDone) next_state = S_AMB;
            S_AMB: if (divDone) next_state = ctrl[CTRL_CURVE_BIT] ? S_CURVE : S_SCALE;
            S_CURVE: next_state = S_SCALE;
            S_SCALE: next_state = S_RATIO;
            S_RATIO: if (divDone) next_state = S_UPDATE;
            S_UPDATE: next_state = S_IDLE;
        endcase
    end

    wire nextDiv = next_state == S_XH || next_state == S_XC || next_state == S_AMB || next_state == S_RATIO;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= S_IDLE;
            stepCnt <= 32'h0;
            divGo <= 1'b0;
            imax <= 16'h0;
            tAmb <= 16'sh0;
            aHeat <= 25'h0;
            aCool <= 25'h0;
            ambQ <= '0;
            ratioSq <= 48'h0;
            kAmbOut <= AMBIENT_CORRECTION_FACTOR_ONE;
            thetaOut <= THETA_RST;
            thetaFrac <= 16'h0;
            stepDone <= 1'b0;
        end
        else
        begin
            state <= next_state;
            stepCnt <= stepCnt == 32'h0 ? 32'(STEP_CYCLES - 1) : stepCnt - 32'h1;
            divGo <= nextDiv && next_state != state;
            stepDone <= state == S_UPDATE;
            if (go)
            begin
                imax <= max2(max2(iL1, iL2), iL3);
                tAmb <= ctrl[CTRL_SRC_BIT] ? rtdT : cfg[CFG_TMAN];
            end
            if (state == S_XH && divDone)
                aHeat <= decayNew;
            if (state == S_XC && divDone)
                aCool <= decayNew;
            if (state == S_AMB && divDone)
                ambQ <= divQ;
            if (state == S_SCALE)
                kAmbOut <= kNew;
            if (state == S_RATIO && divDone)
                ratioSq <= qSq;
            // cold value wins over a step update
            if (coldReq)
            begin
                thetaOut <= coldQ16;
                thetaFrac <= 16'h0;
            end
            else if (state == S_UPDATE)
            begin
                thetaOut <= thetaSum[47:16];
                thetaFrac <= thetaSum[15:0];
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_tick; stepCnt == 32'h0 |=> stepCnt == 32'(STEP_CYCLES - 1); endproperty
    a_tick: assert property (p_tick) else $error("step counter reload wrong");
    property p_step; go |-> ##[1:300] stepDone; endproperty
    a_step: assert property (p_step) else $error("step did not complete");
    property p_imax; go |=> imax >= $past(iL1) && imax >= $past(iL2) && imax >= $past(iL3)
        && (imax == $past(iL1) || imax == $past(iL2) || imax == $past(iL3)); endproperty
    a_imax: assert property (p_imax) else $error("imax is not the phase maximum");
    property p_rise; state == S_UPDATE && heating && !coldReq
        |=> thetaOut >= $past(thetaOut) && thetaOut <= $past(ratioSq[47:16]); endproperty
    a_rise: assert property (p_rise) else $error("heating step out of range");
    property p_bound; state == S_UPDATE && !coldReq && ratioSq <= {32'(THETA_ONE), 16'h0}
        && thetaOut <= 32'(THETA_ONE) |=> thetaOut <= 32'(THETA_ONE); endproperty
    a_bound: assert property (p_bound) else $error("image exceeded full capacity");
    property p_decay; state == S_UPDATE && ratioSq == 48'h0 && !coldReq
        |=> thetaOut <= $past(thetaOut); endproperty
    a_decay: assert property (p_decay) else $error("image rose without current");
    property p_clamp; state == S_SCALE && !ctrl[CTRL_CURVE_BIT] && lowClamp
        |=> kAmbOut == $past(cfg[CFG_KMIN]); endproperty
    a_clamp: assert property (p_clamp) else $error("low clamp factor wrong");
    property p_ref; state == S_SCALE && !ctrl[CTRL_CURVE_BIT] && tAmb == tRef && tRef > tMin
        && tRef < tMax |=> kAmbOut == AMBIENT_CORRECTION_FACTOR_ONE; endproperty
    a_ref: assert property (p_ref) else $error("factor not one at reference");
    property p_src; go |=> tAmb == $past(ctrl[CTRL_SRC_BIT] ? rtdT : cfg[CFG_TMAN]); endproperty
    a_src: assert property (p_src) else $error("wrong ambient source");
    property p_cold; coldReq |=> thetaOut == $past(coldQ16); endproperty
    a_cold: assert property (p_cold) else $error("cold value not loaded");

    c_cold: cover property (coldCmd);
    c_heat: cover property (state == S_UPDATE && heating);
    c_curve: cover property (state == S_CURVE);
    c_write: cover property (doWrite && wrCfg);
endmodule

//--- include/tth_pkg.sv
package tth_pkg;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG_BASE = 8'h04;
    localparam logic [7:0] REG_THETA = 8'h30;
    localparam logic [7:0] REG_AMBIENT_CORRECTION_FACTOR = 8'h34;
    localparam logic [7:0] REG_STATUS = 8'h38;
    localparam logic [7:0] REG_CURVE_BASE = 8'h40;
    localparam int CFG_N = 11;
    localparam int CURVE_N = 10;
    // Setting word indexes from REG_CFG_BASE
    localparam int CFG_PICKUP = 0;
    localparam int CFG_TAUH = 1;
    localparam int CFG_TAUC = 2;
    localparam int CFG_SF = 3;
    localparam int CFG_COLD = 4;
    localparam int CFG_TMAN = 5;
    localparam int CFG_TMIN = 6;
    localparam int CFG_TREF = 7;
    localparam int CFG_TMAX = 8;
    localparam int CFG_KMIN = 9;
    localparam int CFG_KMAX = 10;
    // Control bits
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_CURVE_BIT = 2;
    localparam int CTRL_COLD_BIT = 3;
    // Reset values
    localparam logic [15:0] CFG_RST [CFG_N] = '{16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0258,
        16'h000F, 16'h0000, 16'h0028, 16'h005A, 16'h0400, 16'h0400};
    localparam logic [31:0] THETA_RST = 32'h0000_9999;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Timing
    localparam int STEP_US = 5000;
    localparam int CLK_KHZ = 40000;
    localparam int STEP_CYCLES_DEF = STEP_US * CLK_KHZ / 1000;
    localparam int SEC_PER_MIN = 60;
    localparam int TAU_PER_MIN = 10;
    localparam int XDEN_SCALE = SEC_PER_MIN * 1000000 / (TAU_PER_MIN * STEP_US);
    // Fixed point
    localparam int DIV_W = 40;
    localparam int DECAY_FRAC = 24;
    localparam logic [39:0] DECAY_ONE = 40'h00_0100_0000;
    localparam logic [39:0] SAT24 = 40'h00_00FF_FFFF;
    localparam int THETA_ONE = 65536;
    localparam int PCT_SCALE = 1000;
    localparam int SF_SCALE = 100;
    localparam int AMBIENT_CORRECTION_FACTOR_SHIFT = 10;
    localparam logic [15:0] AMBIENT_CORRECTION_FACTOR_ONE = 16'h0400;

    typedef enum logic [3:0] {S_IDLE, S_XH, S_XC, S_AMB, S_CURVE, S_SCALE, S_RATIO, S_UPDATE} tth_state_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } tth_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tth_axi_rsp_t;

    typedef struct packed {
        logic valid;
        logic [15:0] l1;
        logic [15:0] l2;
        logic [15:0] l3;
        logic [15:0] temp;
    } tth_meas_t;
endpackage

//--- hw/tth_divider.sv
`timescale 1ns/1ps
module tth_divider
    import tth_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Request
    input wire logic start,
    input wire logic [DIV_W-1:0] num,
    input wire logic [DIV_W-1:0] den,
    // Result
    output logic done,
    output logic [DIV_W-1:0] quot
);
    logic [DIV_W:0] rem;
    logic [DIV_W-1:0] dvs;
    logic [5:0] cnt;
    logic busy;
    // Restoring division; a zero divisor gives all ones, i.e. saturation
    wire [DIV_W:0] trial = {rem[DIV_W-1:0], quot[DIV_W-1]};
    wire fits = trial >= {1'b0, dvs};

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rem <= '0;
            dvs <= '0;
            quot <= '0;
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= busy && cnt == 6'h1;
            if (start)
            begin
                rem <= '0;
                dvs <= den;
                quot <= num;
                cnt <= 6'(DIV_W);
                busy <= 1'b1;
            end
            else if (busy)
            begin
                rem <= fits ? trial - {1'b0, dvs} : trial;
                quot <= {quot[DIV_W-2:0], fits};
                cnt <= cnt - 6'h1;
                busy <= cnt != 6'h1;
            end
        end
    end
endmodule

//--- hw/tth_curve_mem.sv
`timescale 1ns/1ps
module tth_curve_mem
    import tth_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Write port
    input wire logic wrEn,
    input wire logic [3:0] wrIdx,
    input wire logic [15:0] wrData,
    // Read port
    input wire logic [3:0] rdIdx,
    output logic [15:0] rdData
);
    logic [15:0] pts [CURVE_N];

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < CURVE_N; i++)
                pts[i] <= AMBIENT_CORRECTION_FACTOR_ONE;
            rdData <= AMBIENT_CORRECTION_FACTOR_ONE;
        end
        else
        begin
            if (wrEn)
                pts[wrIdx] <= wrData;
            rdData <= pts[rdIdx];
        end
    end
endmodule

//--- testbench/tth_meas_model.sv
`timescale 1ns/1ps
module tth_meas_model
    import tth_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Wanted values
    input wire logic [15:0] setL1,
    input wire logic [15:0] setL2,
    input wire logic [15:0] setL3,
    input wire logic [15:0] setTemp,
    // Measurement
    output tth_meas_t meas
);
    // Fresh sample every cycle once out of reset
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            meas <= '0;
        else
            meas <= '{1'b1, setL1, setL2, setL3, setTemp};
    end
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb
    import tth_pkg::*;
;
    logic sys_clk = 0;
    logic nrst = 0;
    tth_axi_req_t req = '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b1, 1'b0, 8'h00, 1'b1};
    tth_axi_rsp_t rsp;
    tth_meas_t meas;
    logic [15:0] lA = 0, lB = 0, lC = 0, tSet = 0;
    logic [31:0] thetaOut, rd, t0;
    logic [15:0] kAmbOut;
    logic stepDone;
    logic [1:0] rs;
    int failCount = 0;
    int samplesChecked = 0;
    int n;
    logic [15:0] tIn [5] = '{16'hFFF6, 16'd20, 16'd40, 16'd65, 16'd200};
    logic [15:0] kExp [5] = '{16'h0200, 16'h0300, 16'h0400, 16'h0500, 16'h0600};

    tth_meas_model tth_meas_model_i (.sys_clk(sys_clk), .nrst(nrst), .setL1(lA), .setL2(lB),
        .setL3(lC), .setTemp(tSet), .meas(meas));
    tth_replica #(.STEP_CYCLES(500)) tth_replica_i (.sys_clk(sys_clk), .nrst(nrst), .axiReq(req),
        .axiRsp(rsp), .meas(meas), .thetaOut(thetaOut), .kAmbOut(kAmbOut), .stepDone(stepDone));

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            failCount++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tick(inout int k);
        @(posedge sys_clk);
        k++;
        if (k > 2000)
        begin
            failCount++;
            $display("BAD %0t wait ran out", $time);
            tallyAndFinish();
        end
    endtask

    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req <= '{1'b1, a, 1'b1, d, 4'hF, 1'b1, 1'b0, 8'h00, 1'b1};
        forever
        begin
            tick(k);
            if (rsp.awready)
                req.awvalid <= 1'b0;
            if (rsp.wready)
                req.wvalid <= 1'b0;
            if (rsp.bvalid)
            begin
                rs = rsp.bresp;
                break;
            end
        end
    endtask

    task automatic axiRd(input logic [7:0] a);
        int k;
        k = 0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        forever
        begin
            tick(k);
            if (rsp.arready)
                req.arvalid <= 1'b0;
            if (rsp.rvalid)
            begin
                rd = rsp.rdata;
                rs = rsp.rresp;
                break;
            end
        end
    endtask

    task automatic cfg(input int idx, input logic [15:0] v);
        axiWr(REG_CFG_BASE + 8'(4 * idx), {16'h0000, v});
    endtask

    task automatic waitStep(output int c);
        c = 0;
        do
            tick(c);
        while (stepDone !== 1'b1);
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        chk(thetaOut, THETA_RST);
        chk({16'h0, kAmbOut}, {16'h0, AMBIENT_CORRECTION_FACTOR_ONE});
        for (int i = 0; i < CFG_N; i++)
        begin
            axiRd(REG_CFG_BASE + 8'(4 * i));
            chk(rd, {16'h0, CFG_RST[i]});
        end
        axiRd(8'h3C);
        chk({30'h0, rs}, {30'h0, RESP_DECERR});
        axiWr(REG_THETA, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_DECERR});
        cfg(CFG_KMIN, 16'h0200);
        cfg(CFG_KMAX, 16'h0600);
        axiWr(REG_CTRL, 32'h1);
        for (int i = 0; i < 5; i++)
        begin
            cfg(CFG_TMAN, tIn[i]);
            waitStep(n);
            waitStep(n);
            chk({16'h0, kAmbOut}, {16'h0, kExp[i]});
        end
        tSet <= 16'd65;
        axiWr(REG_CTRL, 32'h3);
        waitStep(n);
        waitStep(n);
        chk({16'h0, kAmbOut}, 32'h0000_0500);
        tSet <= 16'd20;
        waitStep(n);
        waitStep(n);
        chk({16'h0, kAmbOut}, 32'h0000_0300);
        // Curve point 4 serves 45 degrees on the 0 to 90 span
        axiWr(REG_CURVE_BASE + 8'h10, 32'h0000_0345);
        cfg(CFG_TMAN, 16'h002D);
        axiWr(REG_CTRL, 32'h0000_0005);
        waitStep(n);
        waitStep(n);
        chk({16'h0, kAmbOut}, 32'h0000_0345);
        axiWr(REG_CTRL, 32'h1);
        cfg(CFG_TMAN, 16'd40);
        waitStep(n);
        waitStep(n);
        waitStep(n);
        chk(n, 500);
        // Short time constants make a single step visible in the image
        cfg(CFG_TAUH, 16'h0001);
        cfg(CFG_TAUC, 16'h0002);
        lA <= 16'd50;
        lB <= 16'd120;
        lC <= 16'd80;
        waitStep(n);
        waitStep(n);
        axiRd(REG_STATUS);
        chk({16'h0, rd[31:16]}, 32'd120);
        t0 = thetaOut;
        waitStep(n);
        chk({31'h0, thetaOut > t0}, 32'h1);
        lB <= 16'd0;
        lC <= 16'd0;
        lA <= 16'd0;
        waitStep(n);
        t0 = thetaOut;
        waitStep(n);
        chk({31'h0, thetaOut < t0}, 32'h1);
        cfg(CFG_COLD, 16'd1000);
        axiWr(REG_CTRL, 32'h9);
        chk(thetaOut, 32'h0001_0000);
        lA <= 16'd100;
        lB <= 16'd100;
        lC <= 16'd100;
        repeat (4) waitStep(n);
        chk({31'h0, thetaOut <= 32'h0001_0000}, 32'h1);
        cfg(CFG_SF, 16'd200);
        waitStep(n);
        t0 = thetaOut;
        waitStep(n);
        chk({31'h0, thetaOut < t0}, 32'h1);
        tallyAndFinish();
    end
endmodule
